// ---- hdl/mdms_pkg.sv ----
// Constants shared by both ends of the serial management link.
// Assumes a 100 MHz system clock on each end and a pulled-up data line.
// Overview of operation
// - Thirty-two 16-bit registers per port, serial only
// - Station clock at most 25 MHz, any slower
// - Shared data line driven only when addressed
// - Station sends 32 ones to initialise
// - Ignore everything until full 32-one preamble
// - Bad start, opcode or turnaround drops sync
// - Station resends 32 ones after an error
// - Frames open with 01 after ones
// - Nobody drives first read turnaround bit
// - Device drives zero then 16 data bits
// - Station drives 10 turnaround and write data
// - Status register 01h bit 6 reads one
// - Station may skip preamble once synchronised
// - One idle bit between frames suffices
// - Bit 15 of port A 17h enables mirroring
// - Port A writes also land in port B
// - Reads return only the addressed port
package mdms_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MDC_MIN_PERIOD_NS = 40;
    localparam int MDC_MIN_HALF_CYC =
        (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Both ends resample the line, so half a period needs margin
    localparam int MDC_SAFE_HALF_CYC = 4;
    localparam int MDC_HALF_CYC_DEF = 4;
    localparam int PREAMBLE_LEN = 32;
    localparam int FRAME_LEN = 32;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int NUM_REGS = 32;
    localparam logic [1:0] START_CODE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] TA_WRITE = 2'h2;
    localparam logic [4:0] REG_BASIC_MODE_STATUS = 5'h01;
    localparam logic [4:0] REG_INTERFACE_BYPASS = 5'h17;
    localparam int SIMWRITE_BIT = 15;
    localparam int PRESUP_BIT = 6;
    localparam logic [15:0] BASIC_MODE_STATUS_VAL = 16'h0040;
    localparam logic [15:0] REG_RESET_VAL = 16'h0000;
    localparam logic [4:0] PREAMBLE_LAST = 5'h1F;
    localparam logic [4:0] FIELD5_LAST = 5'h04;
    localparam logic [4:0] DATA_LAST = 5'h0F;
endpackage

// ---- hdl/mdms_if.sv ----
// Two-wire management link joining station and device ends.
// Assumes a pull-up: the data line reads high when nobody drives it.
`timescale 1ns/1ns
interface mdms_if;
    logic mdc;
    logic sta_o;
    logic sta_oe_n;
    logic phy_o;
    logic phy_oe_n;
    logic mdio;

    // ------------------------------------------------------------
    // Resolved line with pull-up
    // ------------------------------------------------------------
    assign mdio = !sta_oe_n ? sta_o : (!phy_oe_n ? phy_o : 1'b1);

    modport station (output mdc, output sta_o, output sta_oe_n,
        input mdio);
    modport phy (input mdc, input mdio, output phy_o, output phy_oe_n);
endinterface

// ---- hdl/mdms_sync.sv ----
// Two-stage synchroniser for clock and data pins, with clock edge detect.
// Assumes pins asynchronous to clk.
`timescale 1ns/1ns
module mdms_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc_pin,
    input wire logic mdio_pin,
    output logic mdc_rise,
    output logic mdio_s
);
    logic [1:0] mdc_ff_r;
    logic [1:0] mdio_ff_r;
    logic mdc_d_r;
    logic [1:0] mdc_ff_nxt;
    logic [1:0] mdio_ff_nxt;
    logic mdc_d_nxt;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb
    begin
        mdc_ff_nxt = {mdc_ff_r[0], mdc_pin};
        mdio_ff_nxt = {mdio_ff_r[0], mdio_pin};
        mdc_d_nxt = mdc_ff_r[1];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdc_ff_r <= 2'h0;
            mdio_ff_r <= 2'h3;
            mdc_d_r <= 1'b0;
        end
        else
        begin
            mdc_ff_r <= mdc_ff_nxt;
            mdio_ff_r <= mdio_ff_nxt;
            mdc_d_r <= mdc_d_nxt;
        end
    end

    assign mdc_rise = mdc_ff_r[1] && !mdc_d_r;
    assign mdio_s = mdio_ff_r[1];
endmodule // mdms_sync

// ---- hdl/mdms_phy.sv ----
// Device end: management slave with two ports of 16-bit registers.
// Assumes the station keeps the clock at or below 25 MHz.
`timescale 1ns/1ns
module mdms_phy
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [4:0] PORTA_ADDR,
    input wire logic [4:0] PORTB_ADDR,
    output logic SYNCED,
    output logic SIMWRITE_EN,
    mdms_if.phy LINK
);
    typedef enum logic [9:0] {
        S_UNSYNC = 10'h001,
        S_IDLE = 10'h002,
        S_START2 = 10'h004,
        S_OP = 10'h008,
        S_PHYAD = 10'h010,
        S_REGAD = 10'h020,
        S_TA1 = 10'h040,
        S_TA2 = 10'h080,
        S_DATA = 10'h100,
        S_GAP = 10'h200
    } mdms_state_t;

    logic mdc_rise;
    logic b;
    mdms_state_t state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic is_rd_r, is_rd_nxt;
    logic hit_r, hit_nxt;
    logic port_r, port_nxt;
    logic [4:0] regad_r, regad_nxt;
    logic o_r, o_nxt;
    logic oe_n_r, oe_n_nxt;
    logic [15:0] mem_r [0:1][0:31];
    logic [15:0] mem_nxt [0:1][0:31];
    logic [4:0] addr5;
    logic [15:0] wdata;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    mdms_sync mdms_sync_inst
    (
        .clk(CLK),
        .rst_n(RST_N),
        .mdc_pin(LINK.mdc),
        .mdio_pin(LINK.mdio),
        .mdc_rise(mdc_rise),
        .mdio_s(b)
    );

    assign addr5 = {sh_r[3:0], b};
    assign wdata = {sh_r[14:0], b};

    // ------------------------------------------------------------
    // Frame decoder and register file, next values
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        is_rd_nxt = is_rd_r;
        hit_nxt = hit_r;
        port_nxt = port_r;
        regad_nxt = regad_r;
        o_nxt = o_r;
        oe_n_nxt = oe_n_r;
        mem_nxt = mem_r;
        if (mdc_rise)
        begin
            case (state_r)
                S_UNSYNC:
                begin
                    if (!b)
                        cnt_nxt = 5'h00;
                    else if (cnt_r == mdms_pkg::PREAMBLE_LAST)
                        state_nxt = S_IDLE;
                    else
                        cnt_nxt = cnt_r + 5'h01;
                end
                S_IDLE:
                begin
                    if (!b)
                        state_nxt = S_START2;
                end
                S_START2:
                begin
                    cnt_nxt = 5'h00;
                    if (b)
                        state_nxt = S_OP;
                    else
                        state_nxt = S_UNSYNC;
                end
                S_OP:
                begin
                    sh_nxt = wdata;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'h01)
                    begin
                        cnt_nxt = 5'h00;
                        is_rd_nxt = ({sh_r[0], b} == mdms_pkg::OP_READ);
                        if ({sh_r[0], b} == mdms_pkg::OP_READ
                            || {sh_r[0], b} == mdms_pkg::OP_WRITE)
                            state_nxt = S_PHYAD;
                        else
                            state_nxt = S_UNSYNC;
                    end
                end
                S_PHYAD:
                begin
                    sh_nxt = wdata;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == mdms_pkg::FIELD5_LAST)
                    begin
                        cnt_nxt = 5'h00;
                        hit_nxt = (addr5 == PORTA_ADDR)
                            || (addr5 == PORTB_ADDR);
                        port_nxt = (addr5 != PORTA_ADDR);
                        state_nxt = S_REGAD;
                    end
                end
                S_REGAD:
                begin
                    sh_nxt = wdata;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == mdms_pkg::FIELD5_LAST)
                    begin
                        regad_nxt = addr5;
                        state_nxt = S_TA1;
                    end
                end
                S_TA1:
                begin
                    if (!b)
                        state_nxt = S_UNSYNC;
                    else
                    begin
                        state_nxt = S_TA2;
                        if (hit_r && is_rd_r)
                        begin
                            oe_n_nxt = 1'b0;
                            o_nxt = 1'b0;
                            if (regad_r != mdms_pkg::REG_BASIC_MODE_STATUS)
                                sh_nxt = mem_r[port_r][regad_r];
                            else
                                sh_nxt = mdms_pkg::BASIC_MODE_STATUS_VAL;
                        end
                    end
                end
                S_TA2:
                begin
                    cnt_nxt = 5'h00;
                    if (!is_rd_r && b)
                        state_nxt = S_UNSYNC;
                    else
                    begin
                        state_nxt = S_DATA;
                        if (hit_r && is_rd_r)
                        begin
                            o_nxt = sh_r[15];
                            sh_nxt = {sh_r[14:0], 1'b0};
                        end
                    end
                end
                S_DATA:
                begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (is_rd_r)
                    begin
                        o_nxt = sh_r[15];
                        sh_nxt = {sh_r[14:0], 1'b0};
                    end
                    else
                        sh_nxt = wdata;
                    if (cnt_r == mdms_pkg::DATA_LAST)
                    begin
                        oe_n_nxt = 1'b1;
                        o_nxt = 1'b1;
                        state_nxt = S_GAP;
                        if (hit_r && !is_rd_r)
                        begin
                            if (regad_r != mdms_pkg::REG_BASIC_MODE_STATUS)
                                mem_nxt[port_r][regad_r] = wdata;
                            if (!port_r && SIMWRITE_EN)
                                mem_nxt[1][regad_r] = wdata;
                        end
                    end
                end
                S_GAP:
                begin
                    if (b)
                        state_nxt = S_IDLE;
                    else
                        state_nxt = S_UNSYNC;
                end
                default:
                begin
                    state_nxt = S_UNSYNC;
                    cnt_nxt = 5'h00;
                end
            endcase
        end
        if (state_nxt == S_UNSYNC && state_r != S_UNSYNC)
            cnt_nxt = 5'h00;
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_r <= S_UNSYNC;
            cnt_r <= 5'h00;
            sh_r <= 16'h0000;
            is_rd_r <= 1'b0;
            hit_r <= 1'b0;
            port_r <= 1'b0;
            regad_r <= 5'h00;
            o_r <= 1'b1;
            oe_n_r <= 1'b1;
            for (int p = 0; p < 2; p++)
            begin
                for (int r = 0; r < mdms_pkg::NUM_REGS; r++)
                begin
                    mem_r[p][r] <= mdms_pkg::REG_RESET_VAL;
                end
            end
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            is_rd_r <= is_rd_nxt;
            hit_r <= hit_nxt;
            port_r <= port_nxt;
            regad_r <= regad_nxt;
            o_r <= o_nxt;
            oe_n_r <= oe_n_nxt;
            mem_r <= mem_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign LINK.phy_o = o_r;
    assign LINK.phy_oe_n = oe_n_r;
    assign SYNCED = (state_r != S_UNSYNC);
    assign SIMWRITE_EN =
        mem_r[0][mdms_pkg::REG_INTERFACE_BYPASS][mdms_pkg::SIMWRITE_BIT];
endmodule // mdms_phy

// ---- hdl/mdms_station.sv ----
// Station end: generates the management clock and runs one frame per request.
// Assumes a device end on the same link answering reads.
`timescale 1ns/1ns
module mdms_station
#(
    parameter int HALF_CYC = mdms_pkg::MDC_HALF_CYC_DEF
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic REQ_PREAMBLE,
    input wire logic [4:0] REQ_PHY_ADDR,
    input wire logic [4:0] REQ_REG_ADDR,
    input wire logic [15:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic [15:0] RSP_RDATA,
    mdms_if.station LINK
);
    typedef enum logic [2:0] {
        T_IDLE = 3'h1,
        T_RUN = 3'h2,
        T_GAP = 3'h4
    } mdms_sta_state_t;

    if (HALF_CYC < mdms_pkg::MDC_MIN_HALF_CYC
        || HALF_CYC < mdms_pkg::MDC_SAFE_HALF_CYC || HALF_CYC > 255)
    begin : g_chk
        $error("HALF_CYC out of range");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    logic mdio_s;
    mdms_sta_state_t state_r, state_nxt;
    logic [7:0] div_r, div_nxt;
    logic mdc_r, mdc_nxt;
    logic [5:0] idx_r, idx_nxt;
    logic [63:0] frame_r, frame_nxt;
    logic [63:0] drive_r, drive_nxt;
    logic rd_r, rd_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rsp_r, rsp_nxt;
    logic tick;

    mdms_sync mdms_sync_inst
    (
        .clk(CLK),
        .rst_n(RST_N),
        .mdc_pin(mdc_r),
        .mdio_pin(LINK.mdio),
        .mdc_rise(),
        .mdio_s(mdio_s)
    );

    assign tick = (div_r == HALF_LAST);
    assign REQ_READY = (state_r == T_IDLE);

    // ------------------------------------------------------------
    // Frame sequencer, next values
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        div_nxt = (state_r == T_IDLE || tick) ? 8'h00 : div_r + 8'h01;
        mdc_nxt = mdc_r;
        idx_nxt = idx_r;
        frame_nxt = frame_r;
        drive_nxt = drive_r;
        rd_nxt = rd_r;
        rdata_nxt = rdata_r;
        rsp_nxt = 1'b0;
        case (state_r)
            T_IDLE:
            begin
                if (REQ_VALID)
                begin
                    state_nxt = T_RUN;
                    rd_nxt = !REQ_WRITE;
                    frame_nxt = {32'hFFFFFFFF, mdms_pkg::START_CODE,
                        REQ_WRITE ? mdms_pkg::OP_WRITE : mdms_pkg::OP_READ,
                        REQ_PHY_ADDR, REQ_REG_ADDR,
                        REQ_WRITE ? mdms_pkg::TA_WRITE : 2'h3,
                        REQ_WRITE ? REQ_WDATA : 16'hFFFF};
                    drive_nxt = REQ_WRITE ? 64'hFFFFFFFFFFFFFFFF
                        : 64'hFFFFFFFFFFFC0000;
                    idx_nxt = REQ_PREAMBLE ? 6'h00 : 6'h20;
                end
            end
            T_RUN:
            begin
                if (tick)
                begin
                    mdc_nxt = !mdc_r;
                    if (!mdc_r)
                    begin
                        if (rd_r && idx_r >= 6'h30)
                            rdata_nxt = {rdata_r[14:0], mdio_s};
                    end
                    else if (idx_r == 6'h3F)
                        state_nxt = T_GAP;
                    else
                        idx_nxt = idx_r + 6'h01;
                end
            end
            T_GAP:
            begin
                if (tick)
                begin
                    mdc_nxt = !mdc_r;
                    if (mdc_r)
                    begin
                        state_nxt = T_IDLE;
                        rsp_nxt = 1'b1;
                    end
                end
            end
            default:
            begin
                state_nxt = T_IDLE;
                mdc_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_r <= T_IDLE;
            div_r <= 8'h00;
            mdc_r <= 1'b0;
            idx_r <= 6'h00;
            frame_r <= 64'h0;
            drive_r <= 64'h0;
            rd_r <= 1'b0;
            rdata_r <= 16'h0000;
            rsp_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            mdc_r <= mdc_nxt;
            idx_r <= idx_nxt;
            frame_r <= frame_nxt;
            drive_r <= drive_nxt;
            rd_r <= rd_nxt;
            rdata_r <= rdata_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Link and answer
    // ------------------------------------------------------------
    assign LINK.mdc = mdc_r;
    assign LINK.sta_o = frame_r[6'h3F - idx_r];
    assign LINK.sta_oe_n = !(state_r == T_RUN && drive_r[6'h3F - idx_r]);
    assign RSP_VALID = rsp_r;
    assign RSP_RDATA = rdata_r;
endmodule // mdms_station

// ---- sim/mdms_link_properties.sv ----
// Checker for the link between the station and device ends.
// Assumes one clock domain for both ends and HALF_CYC of 4.
`timescale 1ns/1ns
module mdms_link_properties
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic mdc,
    input wire logic sta_o,
    input wire logic sta_oe_n,
    input wire logic phy_o,
    input wire logic phy_oe_n,
    input wire logic mdio
);
    logic [7:0] drv_r;
    logic [7:0] drv_nxt;

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // --------
    // Device drive length
    // --------
    always_comb
    begin
        drv_nxt = phy_oe_n ? 8'h00 : drv_r + 8'h01;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            drv_r <= 8'h00;
        else
            drv_r <= drv_nxt;
    end

    // --------
    // Assertions
    // --------
    chk_no_contention:
        assert property (sta_oe_n || phy_oe_n)
        else $error("Both ends drive the line");
    chk_mdc_half_period:
        assert property ($changed(mdc) |=> $stable(mdc)[*3])
        else $error("Management clock too fast");
    chk_read_ta_zero:
        assert property ($fell(phy_oe_n) |-> phy_o == 1'b0)
        else $error("Device turnaround bit not zero");
    chk_read_drive_length:
        assert property ($rose(phy_oe_n) |-> drv_r inside {[8'h87:8'h89]})
        else $error("Device drove wrong number of bits");
    chk_ta1_released:
        assert property ($fell(phy_oe_n) |-> $past(mdio, 3)
            && $past(sta_oe_n, 5))
        else $error("First turnaround bit was driven");
    chk_idle_gap:
        assert property ($rose(sta_oe_n) |-> sta_oe_n[*8])
        else $error("No idle bit between frames");
    chk_phy_bit_stable:
        assert property ($rose(mdc) && !phy_oe_n |-> phy_o == $past(phy_o, 2))
        else $error("Device bit not settled at rising clock");
    chk_sta_bit_stable:
        assert property (mdc && $past(mdc) && !sta_oe_n
            |-> $stable(sta_o) && $stable(sta_oe_n))
        else $error("Station bit changed while clock high");
    chk_first_rise_zero:
        assert property ($rose(mdc) && !phy_oe_n && $past(phy_oe_n, 7)
            |-> mdio == 1'b0)
        else $error("Line not zero in second turnaround bit");

    cov_read_drive: cover property ($fell(phy_oe_n));
    cov_frame_end: cover property ($rose(sta_oe_n) && phy_oe_n);
    cov_mdc_rise: cover property ($rose(mdc));
endmodule // mdms_link_properties

// ---- sim/mdio_management_slave_test.sv ----
// Bench: station and device joined on one link, plus a second device
// bit-banged by the bench with faults. Assumes the hdl files compiled first.
`timescale 1ns/1ns
module mdio_management_slave_test;
    localparam int LIMIT = 60000;
    localparam logic [1:0] ST = mdms_pkg::START_CODE;
    localparam logic [1:0] RD = mdms_pkg::OP_READ;
    localparam logic [1:0] WR = mdms_pkg::OP_WRITE;
    localparam logic [17:0] ONES = 18'h3FFFF;
    localparam logic [17:0] RDV = 18'h20040;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic v = 1'b0;
    logic w = 1'b0;
    logic p = 1'b0;
    logic [4:0] pa = 5'h00;
    logic [4:0] ra = 5'h00;
    logic [15:0] wd = 16'h0000;
    logic rdy, rv, syn, sim, fsyn, smp;
    logic [15:0] rdata;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    mdms_if link_if ();
    mdms_if bad_if ();

    mdms_station mdms_station_inst (.CLK(clk), .RST_N(rst_n),
        .REQ_VALID(v), .REQ_READY(rdy), .REQ_WRITE(w), .REQ_PREAMBLE(p),
        .REQ_PHY_ADDR(pa), .REQ_REG_ADDR(ra), .REQ_WDATA(wd),
        .RSP_VALID(rv), .RSP_RDATA(rdata), .LINK(link_if.station));
    mdms_phy mdms_phy_inst (.CLK(clk), .RST_N(rst_n), .PORTA_ADDR(5'h03),
        .PORTB_ADDR(5'h04), .SYNCED(syn), .SIMWRITE_EN(sim),
        .LINK(link_if.phy));
    mdms_phy mdms_phy_fault_inst (.CLK(clk), .RST_N(rst_n),
        .PORTA_ADDR(5'h03), .PORTB_ADDR(5'h04), .SYNCED(fsyn),
        .SIMWRITE_EN(), .LINK(bad_if.phy));
    mdms_link_properties mdms_link_properties_inst (.CLK(clk),
        .RST_N(rst_n), .mdc(link_if.mdc), .sta_o(link_if.sta_o),
        .sta_oe_n(link_if.sta_oe_n), .phy_o(link_if.phy_o),
        .phy_oe_n(link_if.phy_oe_n), .mdio(link_if.mdio));

    // --------
    // Tasks
    // --------
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task automatic xfer(input logic wr, input logic pre,
        input logic [4:0] a, input logic [4:0] r, input logic [15:0] d);
    begin
        @(negedge clk);
        {v, w, p, pa, ra, wd} = {1'b1, wr, pre, a, r, d};
        while (rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
        v = 1'b0;
        check({17'h0, rdy}, 18'h0);
        while (rv !== 1'b1) @(negedge clk);
        check({17'h0, rdy}, 18'h1);
    end
    endtask

    task automatic rdc(input logic pre, input logic [4:0] a,
        input logic [4:0] r, input logic [15:0] e);
    begin
        xfer(1'b0, pre, a, r, 16'h0000);
        check({2'h0, rdata}, {2'h0, e});
    end
    endtask

    function automatic logic [13:0] hdr(input logic [1:0] s,
        input logic [1:0] o, input logic [4:0] a);
        hdr = {s, o, a, 5'h01};
    endfunction

    task automatic bb(input logic b, input logic drv);
    begin
        bad_if.mdc = 1'b0;
        bad_if.sta_o = b;
        bad_if.sta_oe_n = !drv;
        #62;
        smp = bad_if.mdio;
        bad_if.mdc = 1'b1;
        #63;
    end
    endtask

    task automatic fcase(input logic lead, input int ones,
        input logic [13:0] h, input logic [17:0] e, input logic es);
        logic [17:0] got;
    begin
        bb(lead, 1'b1);
        repeat (ones) bb(1'b1, 1'b1);
        for (int i = 13; i >= 0; i--) bb(h[i], 1'b1);
        for (int i = 0; i < 18; i++)
        begin
            bb(1'b1, 1'b0);
            got = {got[16:0], smp};
        end
        bad_if.mdc = 1'b0;
        check(got, e);
        check({17'h0, fsyn}, {17'h0, es});
    end
    endtask

    task automatic tally_and_finish;
    begin
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // --------
    // Clock, timeout and sequence
    // --------
    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        bad_if.mdc = 1'b0;
        bad_if.sta_o = 1'b1;
        bad_if.sta_oe_n = 1'b1;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check({17'h0, syn}, 18'h0);
        rdc(1'b1, 5'h03, 5'h01, 16'h0040);
        check({17'h0, syn}, 18'h1);
        xfer(1'b1, 1'b0, 5'h03, 5'h05, 16'hA55A);
        rdc(1'b0, 5'h03, 5'h05, 16'hA55A);
        rdc(1'b0, 5'h04, 5'h05, 16'h0000);
        xfer(1'b1, 1'b0, 5'h03, 5'h01, 16'hFFFF);
        rdc(1'b0, 5'h03, 5'h01, 16'h0040);
        rdc(1'b0, 5'h1F, 5'h02, 16'hFFFF);
        xfer(1'b1, 1'b0, 5'h03, 5'h17, 16'h8000);
        check({17'h0, sim}, 18'h1);
        xfer(1'b1, 1'b0, 5'h03, 5'h07, 16'h1234);
        rdc(1'b0, 5'h04, 5'h07, 16'h1234);
        xfer(1'b1, 1'b0, 5'h04, 5'h07, 16'h5678);
        rdc(1'b0, 5'h03, 5'h07, 16'h1234);
        rdc(1'b0, 5'h04, 5'h07, 16'h5678);
        xfer(1'b1, 1'b0, 5'h03, 5'h17, 16'h0000);
        check({17'h0, sim}, 18'h0);
        xfer(1'b1, 1'b0, 5'h03, 5'h07, 16'h9ABC);
        rdc(1'b0, 5'h04, 5'h07, 16'h5678);
        for (int i = 0; i < 32; i++)
            xfer(1'b1, 1'b0, 5'h04, 5'(i), {11'h5A3, 5'(i)});
        for (int i = 0; i < 32; i++)
            rdc(1'b0, 5'h04, 5'(i),
                i == 1 ? 16'h0040 : {11'h5A3, 5'(i)});
        check({17'h0, sim}, 18'h0);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        check({17'h0, syn}, 18'h0);
        rdc(1'b0, 5'h03, 5'h01, 16'hFFFF);
        check({17'h0, syn}, 18'h0);
        rdc(1'b1, 5'h03, 5'h05, 16'h0000);
        @(negedge clk);
        #1;
        fcase(1'b0, 0, hdr(ST, RD, 5'h03), ONES, 1'b0);
        fcase(1'b0, 31, hdr(ST, RD, 5'h03), ONES, 1'b0);
        fcase(1'b0, 32, hdr(ST, RD, 5'h03), RDV, 1'b1);
        fcase(1'b1, 0, hdr(ST, RD, 5'h03), RDV, 1'b1);
        fcase(1'b1, 0, hdr(ST, RD, 5'h1F), ONES, 1'b1);
        fcase(1'b1, 0, hdr(2'h0, RD, 5'h03), ONES, 1'b0);
        fcase(1'b0, 32, hdr(ST, RD, 5'h04), RDV, 1'b1);
        fcase(1'b1, 0, hdr(ST, 2'h3, 5'h03), ONES, 1'b0);
        fcase(1'b0, 32, hdr(ST, RD, 5'h03), RDV, 1'b1);
        fcase(1'b1, 0, hdr(ST, 2'h0, 5'h03), ONES, 1'b0);
        fcase(1'b0, 32, hdr(ST, RD, 5'h03), RDV, 1'b1);
        fcase(1'b1, 0, hdr(ST, WR, 5'h03), ONES, 1'b0);
        tally_and_finish();
    end
endmodule // mdio_management_slave_test
